// ==== hw/ppe_core.sv ====
// Purpose: bus parity generation, parity checking and error reporting
// Assumes: bus signals sampled on ref_clk rising edge; phase info from transaction engine
// Notes:   master halts after a data parity error as master reader until host clears system error
`timescale 1ns/10ps
// Contract
// RULE1 - drive even parity over 32 address/data and 4 command/byte-enable lines
// RULE2 - parity covers all lines in every phase, meaningful or not
// RULE3 - sample every bus signal on the rising bus clock edge
// RULE4 - master data parity error sets system error bit and data parity report bit
// RULE5 - after that error finish burst, stop, resume when host clears system error
// RULE6 - assert parity error pin on error as master reader or written target
// RULE7 - system holds reset low at least ten running bus clocks
// RULE8 - in reset all bus outputs float and open-drain signals release; code drives req_n high in reset, with no enable
// RULE9 - address parity error with enable set drives system error, sets signalled bit
// RULE10 - system error pin asserts two clocks after the failing address
// RULE11 - request output asserts low whenever the device needs the bus
// RULE12 - transmit enable shows activity; in pcs mode mirrors mac transmit activity
// RULE13 - address match output asserts when a packet passes address recognition
// RULE14 - collision input is synchronised since it changes asynchronously
// RULE15 - no idle logic relies on the recovered receive clock
// RULE16 - software clears status bits by writing one; interrupt then releases
// RULE17 - parity is driven one clock after the phase it covers
// RULE18 - parity and parity error driven only while this agent sources data; code drives parity error as master reader or written target
module ppe_core import ppe_pkg::*; #(
  parameter int unsigned AD_WIDTH = AD_W
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  // bus lines sampled from the pins
  input  wire ppe_bus_word_t bus_in,
  input  wire ppe_phase_t    phase,
  input  wire logic          par_oe_req,   // engine drives ad/cbe this phase
  input  wire logic          burst_done,   // current master burst finished
  input  wire logic          need_bus,     // engine wants ownership
  // software status controls
  input  wire logic          serr_en,      // config_command_status system error enable
  input  wire logic          clr_serr_evt, // write one to event_status_register system error
  input  wire logic          clr_dpr,      // write one to data parity report
  input  wire logic          clr_sig_serr, // write one to signalled system error
  // network side
  input  wire logic          pcs_mode,     // operating_mode_register pcs select
  input  wire logic          mac_tx_active,
  input  wire logic          addr_matched,
  input  wire logic          srl_collision_async,
  // bus outputs
  output logic               par_o,
  output logic               par_oe,
  output logic               perr_n_o,
  output logic               perr_oe,
  output logic               serr_n_o,
  output logic               serr_oe,
  output logic               req_n,
  // status and control
  output ppe_status_t        status,
  output logic               master_halt,
  output logic               irq_n,
  // network outputs
  output logic               phy_tx_en,
  output logic               rcv_match_o,
  output logic               collision_sync
);
  // ===========================================================
  // parity function
  function automatic logic even_par(input ppe_bus_word_t w);
    even_par = ^{w.ad, w.cbe_n};
  endfunction

  // ===========================================================
  // registers
  logic        par_ff, par_oe_ff;
  logic        perr_ff, serr_ff;
  logic [1:0]  apar_pipe_ff;
  logic        req_ff, halt_ff, pend_halt_ff;
  ppe_status_t stat_ff;
  logic        irq_ff, txen_ff, match_ff;
  logic        addr_q_ff, we_src_q_ff;
  ppe_bus_word_t word_q_ff;
  logic        mr_q_ff, tw_q_ff, dphase_q_ff;

  // ===========================================================
  // decode
  wire calc_par   = even_par(bus_in);                           // RULE1 RULE2
  wire par_bad    = (even_par(word_q_ff) != phase.par_in);
  wire apar_err   = addr_q_ff && !we_src_q_ff && par_bad;
  wire dpar_err   = dphase_q_ff && (mr_q_ff || tw_q_ff) && par_bad;
  wire m_dpar_err = dpar_err && mr_q_ff;
  wire serr_fire  = apar_pipe_ff[0] && serr_en;                 // RULE9
  wire nxt_req    = need_bus && !halt_ff;                       // RULE11 RULE5
  wire nxt_txen   = mac_tx_active;                              // RULE12

  // ===========================================================
  // phase capture, one clock behind the bus
  always_ff @(posedge ref_clk or negedge rstn) begin             // RULE3
    if (!rstn) begin
      word_q_ff   <= '0;
      addr_q_ff   <= 1'b0;
      dphase_q_ff <= 1'b0;
      we_src_q_ff <= 1'b0;
      mr_q_ff     <= 1'b0;
      tw_q_ff     <= 1'b0;
    end else begin
      word_q_ff   <= bus_in;
      addr_q_ff   <= phase.addr_phase;
      dphase_q_ff <= phase.data_phase;
      we_src_q_ff <= phase.we_source;
      mr_q_ff     <= phase.master_read;
      tw_q_ff     <= phase.target_write;
    end
  end

  // parity drive, one clock after the phase, only when sourcing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      par_ff    <= 1'b0;
      par_oe_ff <= 1'b0;                                        // RULE8
    end else begin
      par_ff    <= calc_par;                                    // RULE17
      par_oe_ff <= par_oe_req;                                  // RULE18
    end
  end

  // parity error pin and system error pipeline
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      perr_ff      <= 1'b0;                                     // RULE8
      serr_ff      <= 1'b0;
      apar_pipe_ff <= '0;
    end else begin
      perr_ff      <= dpar_err;                                 // RULE6 RULE18
      apar_pipe_ff <= {1'b0, apar_err};
      serr_ff      <= serr_fire;                                // RULE10
    end
  end

  // status bits, set wins over clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stat_ff <= '0;
    end else begin
      stat_ff.serr_evt <= m_dpar_err || (stat_ff.serr_evt && !clr_serr_evt); // RULE4 RULE16
      stat_ff.dpr      <= m_dpar_err || (stat_ff.dpr && !clr_dpr);           // RULE4
      stat_ff.sig_serr <= serr_fire || (stat_ff.sig_serr && !clr_sig_serr);  // RULE9
    end
  end

  // master halt: finish burst, then stop until system error cleared
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_halt_ff <= 1'b0;
      halt_ff      <= 1'b0;
    end else begin
      if (m_dpar_err && !burst_done) begin
        pend_halt_ff <= 1'b1;
      end else if (burst_done) begin
        pend_halt_ff <= 1'b0;
      end
      if ((m_dpar_err || pend_halt_ff) && burst_done) begin      // RULE5
        halt_ff <= 1'b1;
      end else if (!stat_ff.serr_evt && !pend_halt_ff && !m_dpar_err) begin
        halt_ff <= 1'b0;
      end
    end
  end

  // request, interrupt and network indications
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_ff   <= 1'b0;
      irq_ff   <= 1'b0;
      txen_ff  <= 1'b0;
      match_ff <= 1'b0;
    end else begin
      req_ff   <= nxt_req;
      irq_ff   <= stat_ff.serr_evt;                             // RULE16
      txen_ff  <= nxt_txen;
      match_ff <= addr_matched;                                 // RULE13
    end
  end

  // collision synchroniser; no logic here runs on the receive clock
  ppe_sync u_clsn_sync (                                        // RULE14 RULE15
    .clk  (ref_clk),
    .rstn (rstn),
    .din  (srl_collision_async),
    .dout (collision_sync)
  );

  // ===========================================================
  // outputs
  assign par_o       = par_ff;
  assign par_oe      = par_oe_ff;
  assign perr_n_o    = 1'b0;
  assign perr_oe     = perr_ff;
  assign serr_n_o    = 1'b0;
  assign serr_oe     = serr_ff;
  assign req_n       = !req_ff;
  assign status      = stat_ff;
  assign master_halt = halt_ff;
  assign irq_n       = !irq_ff;
  assign phy_tx_en   = txen_ff;
  assign rcv_match_o = match_ff;

  // ===========================================================
  // assertions
  a_par_timing: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE17
    par_oe_req |=> (par_o == $past(calc_par)))
    else $error("parity not driven one clock after phase");
  a_par_release: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE18
    !par_oe_req |=> !par_oe)
    else $error("parity driven while not sourcing");
  a_serr_delay: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE10
    (phase.addr_phase && !phase.we_source && serr_en ##1 par_bad && serr_en) |=> ##1 serr_oe)
    else $error("system error not two clocks after bad address");
  a_serr_gate: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE9
    serr_oe |-> $past(serr_en))
    else $error("system error without enable");
  a_perr_pin: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE6
    dpar_err |=> perr_oe)
    else $error("parity error pin missed");
  a_dpr_set: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE4
    m_dpar_err |=> status.dpr && status.serr_evt)
    else $error("master parity status not set");
  a_halt_req: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE5
    master_halt |=> req_n)
    else $error("request while halted");
  a_req_follow: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE11
    (need_bus && !master_halt) |=> !req_n)
    else $error("request not asserted");
  a_txen_mirror: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE12
    phy_tx_en == $past(mac_tx_active))
    else $error("transmit enable mismatch");
  a_irq_release: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE16
    (status.serr_evt && clr_serr_evt && !m_dpar_err) |=> ##1 irq_n)
    else $error("interrupt not released");
  c_master_perr: cover property (@(posedge ref_clk) disable iff (!rstn) m_dpar_err);
  c_serr_pulse: cover property (@(posedge ref_clk) disable iff (!rstn) serr_oe);
  c_halt_resume: cover property (@(posedge ref_clk) disable iff (!rstn)
    master_halt ##[1:20] !master_halt);
endmodule

// ==== hw/ppe_pkg.sv ====
// Purpose: shared constants and carriers for the bus parity and error block
// Assumes: single bus clock domain, 25 MHz nominal
// Notes:   status bit positions follow the register layout of the device
package ppe_pkg;
  // ===========================================================
  // bit positions
  localparam int unsigned SERR_EVT_BIT   = 13;  // event_status_register system error
  localparam int unsigned SERR_EN_BIT    = 8;   // config_command_status system error enable
  localparam int unsigned DPR_BIT        = 24;  // config_command_status data parity report
  localparam int unsigned SIG_SERR_BIT   = 30;  // config_command_status signalled system error
  localparam int unsigned PCS_MODE_BIT   = 23;  // operating_mode_register pcs select
  // ===========================================================
  // widths and timing
  localparam int unsigned AD_W           = 32;
  localparam int unsigned CBE_W          = 4;
  localparam int unsigned RESET_MIN_CYC  = 10;  // least reset hold, bus clocks
  localparam int unsigned SERR_DELAY_CYC = 2;   // address clock to system error
  localparam int unsigned SYNC_DEPTH     = 3;
  localparam int unsigned CLK_MHZ        = 25;
  // ===========================================================
  // carriers
  typedef struct packed {
    logic [AD_W-1:0]  ad;
    logic [CBE_W-1:0] cbe_n;
  } ppe_bus_word_t;

  typedef struct packed {
    logic addr_phase;   // an address was on the bus this clock
    logic data_phase;   // a data phase completed this clock
    logic we_source;    // this device drove ad/cbe in that phase
    logic master_read;  // device is master reading
    logic target_write; // device is target being written
    logic par_in;       // parity sampled one clock after the phase
  } ppe_phase_t;

  typedef struct packed {
    logic serr_evt;     // event status system error
    logic dpr;          // data parity report
    logic sig_serr;     // signalled system error
  } ppe_status_t;
endpackage

// ==== hw/ppe_sync.sv ====
// Purpose: three flop synchroniser with agreement filter
// Assumes: input asynchronous to clk
// Notes:   first flop is read only by the second
`timescale 1ns/10ps
module ppe_sync import ppe_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // data
  input  wire logic din,
  output logic      dout
);
  logic [SYNC_DEPTH-1:0] sh_ff;
  logic                  q_ff;
  wire                   agree = (sh_ff[1] == sh_ff[2]);

  // shift chain and filtered output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_ff <= '0;
      q_ff  <= 1'b0;
    end else begin
      sh_ff <= {sh_ff[1:0], din};
      if (agree) begin
        q_ff <= sh_ff[2];
      end
    end
  end

  assign dout = q_ff;
endmodule

// ==== test/ppe_bus_model.sv ====
// Purpose: far side pin model for the parity and error lines
// Assumes: pull-ups on both open-drain error lines
// Notes:   a released parity line toggles so a stale value never matches
`timescale 1ns/10ps
module ppe_bus_model (
  // clock
  input  wire logic ref_clk,
  // device drivers
  input  wire logic par_o,
  input  wire logic par_oe,
  input  wire logic perr_n_o,
  input  wire logic perr_oe,
  input  wire logic serr_n_o,
  input  wire logic serr_oe,
  // resolved pins
  output logic      par_pin,
  output logic      perr_n_pin,
  output logic      serr_n_pin
);
  // ============================================================
  // pin resolution
  logic par_last = 1'b0;
  always @(posedge ref_clk) par_last <= par_pin;
  assign par_pin    = par_oe ? par_o : ~par_last;
  assign perr_n_pin = perr_oe ? perr_n_o : 1'b1;
  assign serr_n_pin = serr_oe ? serr_n_o : 1'b1;
endmodule

// ==== test/pci_parity_error_reporting_tb.sv ====
// Purpose: self-checking bench for the parity and error block
// Assumes: inputs change at the falling edge, outputs read there too
// Notes:   reset first, then parity rows, error and network cases
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module pci_parity_error_reporting_tb import ppe_pkg::*;;
  // ============================================================
  // signals
  typedef struct packed {ppe_bus_word_t w; logic p;} ppe_row_t;
  logic ref_clk = 1'b0, rstn = 1'b0;
  ppe_bus_word_t bus = '0;
  ppe_phase_t ph = '0;
  logic oe_req = 0, bdone = 0, need = 0, sen = 0, c_evt = 0, c_dpr = 0, c_sig = 0;
  logic pcs = 0, mtx = 0, amt = 0, col = 0;
  logic par_o, par_oe, perr_n_o, perr_oe, serr_n_o, serr_oe, req_n, halt, irq_n;
  logic tx_en, match, col_s, par_pin, perr_n_pin, serr_n_pin;
  ppe_status_t st;
  int error_cnt = 0, checks = 0, cyc = 0;
  ppe_row_t rows[6] = '{'{'{32'h0, 4'h0}, 1'b0}, '{'{32'hffffffff, 4'hf}, 1'b0},
    '{'{32'h1, 4'h0}, 1'b1}, '{'{32'h0, 4'h8}, 1'b1},
    '{'{32'h80000000, 4'h7}, 1'b0}, '{'{32'ha5a5a5a5, 4'he}, 1'b1}};
  // ============================================================
  // clock, design and far side
  always #20 ref_clk = ~ref_clk;
  ppe_core dut_u (.ref_clk(ref_clk), .rstn(rstn), .bus_in(bus), .phase(ph),
    .par_oe_req(oe_req), .burst_done(bdone), .need_bus(need), .serr_en(sen),
    .clr_serr_evt(c_evt), .clr_dpr(c_dpr), .clr_sig_serr(c_sig), .pcs_mode(pcs),
    .mac_tx_active(mtx), .addr_matched(amt), .srl_collision_async(col),
    .par_o(par_o), .par_oe(par_oe), .perr_n_o(perr_n_o), .perr_oe(perr_oe),
    .serr_n_o(serr_n_o), .serr_oe(serr_oe), .req_n(req_n), .status(st),
    .master_halt(halt), .irq_n(irq_n), .phy_tx_en(tx_en), .rcv_match_o(match),
    .collision_sync(col_s));
  ppe_bus_model bus_u (.ref_clk(ref_clk), .par_o(par_o), .par_oe(par_oe),
    .perr_n_o(perr_n_o), .perr_oe(perr_oe), .serr_n_o(serr_n_o), .serr_oe(serr_oe),
    .par_pin(par_pin), .perr_n_pin(perr_n_pin), .serr_n_pin(serr_n_pin));
  // ============================================================
  // closing report and hang guard
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic nx(int n); repeat (n) @(negedge ref_clk); endtask
  // bad phase at one edge, wrong parity pin the next
  task automatic bad_phase(logic a, logic rd);
    nx(1); ph = '0; ph.addr_phase = a; ph.data_phase = !a; ph.master_read = rd;
    bus = '0; need = 1;
    nx(1); ph = '0; ph.par_in = 1'b1; bdone = !a;
    nx(1); ph = '0; bdone = 0;
    `CHK({serr_oe, perr_oe, perr_n_pin}, {1'b0, !a, a})
    nx(1);
  endtask
  // ============================================================
  // main sequence
  initial begin
    nx(10);
    `CHK({par_oe, perr_oe, serr_oe, req_n, irq_n}, 5'b00011)
    `CHK({perr_n_pin, serr_n_pin}, 2'b11)
    rstn = 1; $display("test reset done");
    foreach (rows[i]) begin
      nx(1); ph = '0; ph.addr_phase = 1; ph.we_source = 1; oe_req = 1; bus = rows[i].w;
      nx(1); `CHK({par_oe, par_pin}, {1'b1, rows[i].p})
      ph = '0; oe_req = 0; bus = ~bus;
    end
    nx(2); `CHK(par_oe, 1'b0)
    $display("test parity done");
    sen = 1; bad_phase(1, 0);
    `CHK({serr_oe, serr_n_pin, st.sig_serr}, 3'b101)
    nx(1); `CHK(serr_oe, 1'b0)
    c_sig = 1; nx(1); c_sig = 0; sen = 0; bad_phase(1, 0);
    `CHK({serr_oe, st.sig_serr}, 2'b00)
    $display("test address error done");
    bad_phase(0, 1);
    `CHK({perr_oe, perr_n_pin, st.dpr, st.serr_evt}, 4'b0111)
    nx(2); `CHK({halt, req_n, irq_n}, 3'b110)
    c_dpr = 1; c_evt = 1; nx(1); c_dpr = 0; c_evt = 0;
    nx(3); `CHK({halt, req_n, irq_n, st.dpr}, 4'b0010)
    need = 0; nx(2); `CHK(req_n, 1'b1)
    $display("test data error done");
    pcs = 1; mtx = 1; amt = 1; col = 1;
    nx(6); `CHK({tx_en, match, col_s}, 3'b111)
    mtx = 0; amt = 0; col = 0;
    nx(6); `CHK({tx_en, match, col_s}, 3'b000)
    $display("test network done");
    give_verdict();
  end
endmodule
